// ### hw/mid_decoder.sv
// 14-bit instruction decoder and sequencer with a wishbone register port
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "mid_cfg.svh"
module mid_decoder
	import mid_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  port_pins_i,
	input  wire logic        irq_i,
	output logic             file_we_o,
	output logic      [6:0]  file_addr_o,
	output logic      [7:0]  file_data_o,
	output logic             pc_load_o,
	output logic      [10:0] pc_target_o,
	output logic             stack_push_o,
	output logic             stack_pop_o,
	output logic             skip_o,
	output logic             wdt_clear_o,
	output logic             standby_o,
	output logic             prescaler_clear_o,
	output logic             busy_o
);
	mid_state_e  state;
	logic [1:0]  qcnt;
	logic [13:0] insn;
	logic [7:0]  operand;
	logic [7:0]  acc;
	logic [4:0]  status;
	logic [17:0] ctrl;
	logic [7:0]  last_res;
	logic        vec;
	logic        last_two;
	logic        last_skip;
	// 9-bit add with nibble carry in bit 9, shared by add and subtract
	function automatic logic [9:0] mid_add(input logic [7:0] a,
		input logic [7:0] b, input logic ci);
		logic [4:0] lo;
		logic [8:0] s;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		return {lo[4], s};
	endfunction
	// operand fields of the word
	wire logic [6:0]  f_addr = insn[6:0];
	wire logic        dest   = insn[7];
	wire logic [2:0]  bitn   = insn[9:7];
	wire logic [7:0]  lit8   = insn[7:0];
	wire logic [10:0] lit11  = insn[10:0];
	// a read-modify-write of the port sees the pins
	wire logic [7:0] opnd = (f_addr == ctrl[6:0]) ? port_pins_i : operand;
	wire logic [7:0] bmask = 8'h01 << bitn;
	wire logic       bval  = |(opnd & bmask);
	wire logic [9:0] add_f = mid_add(acc, opnd, 1'b0);
	wire logic [9:0] sub_f = mid_add(opnd, ~acc, 1'b1);
	wire logic [9:0] add_l = mid_add(lit8, acc, 1'b0);
	wire logic [9:0] sub_l = mid_add(lit8, ~acc, 1'b1);
	// bus decode
	wire logic req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic wr     = req & wb_we_i & wb_sel_i[0];
	wire logic start  = wr & (wb_adr_i == `MID_REG_INSN) & (state == MID_IDLE);
	wire logic commit = (state == MID_EXEC) &
		(qcnt == 2'(`MID_OSC_PER_CYC - 1));
	wire logic irq_go = (state == MID_IDLE) & irq_i & ctrl[`MID_CT_GIE] &
		~start;
	// decoded effect of the current word
	logic [7:0] res;
	logic       to_acc, to_file, c_n, dc_n;
	logic       up_c, up_dc, up_z, skip, pc_chg, push, pop;
	logic       gie_set, wdt_clr, stby, clr_wd;
	// opcode decode; x positions are wildcards so either value decodes
	// the same
	always_comb begin
		res = 8'h00;
		{to_acc, to_file} = 2'b00;
		c_n = status[`MID_ST_C];
		dc_n = status[`MID_ST_DC];
		{up_c, up_dc, up_z, skip} = 4'h0;
		{pc_chg, push, pop, gie_set} = 4'h0;
		{wdt_clr, stby, clr_wd} = 3'h0;
		casez (insn)
		`MID_W_CLRWD: begin
			wdt_clr = 1'b1;
			clr_wd = 1'b1;
		end
		`MID_W_STBY: begin
			wdt_clr = 1'b1;
			stby = 1'b1;
		end
		`MID_W_IRET: begin
			pop = 1'b1;
			pc_chg = 1'b1;
			gie_set = 1'b1;
		end
		`MID_W_RET: begin
			pop = 1'b1;
			pc_chg = 1'b1;
		end
		14'b00_0000_0??0_0000: ;  // no_operation
		14'b00_0000_1???_????: begin
			res = acc;
			to_file = 1'b1;
		end
		14'b00_0001_????_????: begin
			res = 8'h00;
			to_file = dest;
			to_acc = ~dest;
			up_z = 1'b1;
		end
		14'b00_0010_????_????: begin
			res = sub_f[7:0];
			c_n = sub_f[8];
			dc_n = sub_f[9];
			{up_c, up_dc, up_z} = 3'b111;
		end
		14'b00_0011_????_????: begin
			res = opnd - 8'h01;
			up_z = 1'b1;
		end
		14'b00_0100_????_????: begin
			res = acc | opnd;
			up_z = 1'b1;
		end
		14'b00_0101_????_????: begin
			res = acc & opnd;
			up_z = 1'b1;
		end
		14'b00_0110_????_????: begin
			res = acc ^ opnd;
			up_z = 1'b1;
		end
		14'b00_0111_????_????: begin
			res = add_f[7:0];
			c_n = add_f[8];
			dc_n = add_f[9];
			{up_c, up_dc, up_z} = 3'b111;
		end
		14'b00_1000_????_????: begin
			res = opnd;
			up_z = 1'b1;
		end
		14'b00_1001_????_????: begin
			res = ~opnd;
			up_z = 1'b1;
		end
		14'b00_1010_????_????: begin
			res = opnd + 8'h01;
			up_z = 1'b1;
		end
		14'b00_1011_????_????: begin
			res = opnd - 8'h01;
			skip = (res == 8'h00);
		end
		14'b00_1100_????_????: begin
			res = {status[`MID_ST_C], opnd[7:1]};
			c_n = opnd[0];
			up_c = 1'b1;
		end
		14'b00_1101_????_????: begin
			res = {opnd[6:0], status[`MID_ST_C]};
			c_n = opnd[7];
			up_c = 1'b1;
		end
		14'b00_1110_????_????: res = {opnd[3:0], opnd[7:4]};
		14'b00_1111_????_????: begin
			res = opnd + 8'h01;
			skip = (res == 8'h00);
		end
		14'b01_00??_????_????: begin
			res = opnd & ~bmask;
			to_file = 1'b1;
		end
		14'b01_01??_????_????: begin
			res = opnd | bmask;
			to_file = 1'b1;
		end
		14'b01_10??_????_????: skip = ~bval;
		14'b01_11??_????_????: skip = bval;
		14'b10_0???_????_????: begin
			push = 1'b1;
			pc_chg = 1'b1;
		end
		14'b10_1???_????_????: pc_chg = 1'b1;
		14'b11_00??_????_????: begin
			res = lit8;
			to_acc = 1'b1;
		end
		14'b11_01??_????_????: begin
			res = lit8;
			to_acc = 1'b1;
			pop = 1'b1;
			pc_chg = 1'b1;
		end
		14'b11_1000_????_????: begin
			res = lit8 | acc;
			to_acc = 1'b1;
			up_z = 1'b1;
		end
		14'b11_1001_????_????: begin
			res = lit8 & acc;
			to_acc = 1'b1;
			up_z = 1'b1;
		end
		14'b11_1010_????_????: begin
			res = lit8 ^ acc;
			to_acc = 1'b1;
			up_z = 1'b1;
		end
		14'b11_110?_????_????: begin
			res = sub_l[7:0];
			c_n = sub_l[8];
			dc_n = sub_l[9];
			to_acc = 1'b1;
			{up_c, up_dc, up_z} = 3'b111;
		end
		14'b11_111?_????_????: begin
			res = add_l[7:0];
			c_n = add_l[8];
			dc_n = add_l[9];
			to_acc = 1'b1;
			{up_c, up_dc, up_z} = 3'b111;
		end
		default: ;
		endcase
		// byte group routes by the destination bit
		if (insn[13:12] == 2'b00 && insn[11:8] > 4'h1) begin
			to_acc = ~dest;
			to_file = dest;
		end
	end
	// branches and taken skips spend a dummy cycle
	wire logic two_cyc = vec | pc_chg | skip;
	wire logic file_wr = ~vec & to_file;
	// timer count written while prescaler belongs to it
	wire logic psc_clr = file_wr & (f_addr == ctrl[14:8]) &
		ctrl[`MID_CT_PSA];
	// sequencer: four clocks per instruction cycle
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			state <= MID_IDLE;
			qcnt <= 2'd0;
			vec <= 1'b0;
		end else begin
			qcnt <= (state == MID_IDLE) ? 2'd0 : qcnt + 2'd1;
			case (state)
			MID_IDLE: begin
				if (start || irq_go) begin
					state <= MID_EXEC;
					vec <= irq_go;
				end
			end
			MID_EXEC: begin
				if (commit)
					state <= two_cyc ? MID_DUMMY : MID_IDLE;
			end
			MID_DUMMY: begin
				if (qcnt == 2'(`MID_OSC_PER_CYC - 1))
					state <= MID_IDLE;
			end
			default: state <= MID_IDLE;
			endcase
		end
	end
	// architectural state and one-cycle side-effect pulses
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			insn <= 14'h0000;
			operand <= 8'h00;
			acc <= 8'h00;
			status <= `MID_STATUS_RST;
			ctrl <= `MID_CTRL_RST;
			last_res <= 8'h00;
			last_two <= 1'b0;
			last_skip <= 1'b0;
			file_we_o <= 1'b0;
			file_addr_o <= 7'h00;
			file_data_o <= 8'h00;
			pc_load_o <= 1'b0;
			pc_target_o <= 11'h000;
			stack_push_o <= 1'b0;
			stack_pop_o <= 1'b0;
			skip_o <= 1'b0;
			wdt_clear_o <= 1'b0;
			standby_o <= 1'b0;
			prescaler_clear_o <= 1'b0;
		end else begin
			// software writes; a word arriving while busy is dropped
			if (start)
				insn <= wb_dat_i[13:0];
			if (wr && wb_adr_i == `MID_REG_OPERAND)
				operand <= wb_dat_i[7:0];
			if (wr && wb_adr_i == `MID_REG_ACC)
				acc <= wb_dat_i[7:0];
			if (wr && wb_adr_i == `MID_REG_STATUS)
				status <= wb_dat_i[4:0];
			if (wr && wb_adr_i == `MID_REG_CTRL)
				ctrl <= wb_dat_i[17:0];
			file_we_o <= 1'b0;
			pc_load_o <= 1'b0;
			stack_push_o <= 1'b0;
			stack_pop_o <= 1'b0;
			skip_o <= 1'b0;
			wdt_clear_o <= 1'b0;
			standby_o <= 1'b0;
			prescaler_clear_o <= 1'b0;
			// commit comes last so hardware updates win over software
			if (commit) begin
				last_two <= two_cyc;
				last_skip <= ~vec & skip;
				if (vec) begin
					pc_load_o <= 1'b1;
					pc_target_o <= `MID_IRQ_VECTOR;
					stack_push_o <= 1'b1;
					ctrl[`MID_CT_GIE] <= 1'b0;
				end else begin
					last_res <= res;
					if (to_acc)
						acc <= res;
					file_we_o <= file_wr;
					file_addr_o <= f_addr;
					file_data_o <= res;
					prescaler_clear_o <= psc_clr;
					pc_load_o <= pc_chg & ~pop;
					pc_target_o <= lit11;
					stack_push_o <= push;
					stack_pop_o <= pop;
					skip_o <= skip;
					wdt_clear_o <= wdt_clr;
					standby_o <= stby;
					if (gie_set)
						ctrl[`MID_CT_GIE] <= 1'b1;
					if (up_c)
						status[`MID_ST_C] <= c_n;
					if (up_dc)
						status[`MID_ST_DC] <= dc_n;
					if (up_z)
						status[`MID_ST_Z] <= (res == 8'h00);
					if (wdt_clr) begin
						status[`MID_ST_TO] <= 1'b1;
						status[`MID_ST_PD] <= clr_wd;
					end
				end
			end
		end
	end
	// read mux; unmapped offsets read zero but still acknowledge
	wire logic [31:0] rd_mux =
		(wb_adr_i == `MID_REG_INSN)    ? {18'h0_0000, insn} :
		(wb_adr_i == `MID_REG_OPERAND) ? {24'h00_0000, operand} :
		(wb_adr_i == `MID_REG_ACC)     ? {24'h00_0000, acc} :
		(wb_adr_i == `MID_REG_STATUS)  ? {27'h000_0000, status} :
		(wb_adr_i == `MID_REG_RESULT)  ? {24'h00_0000, last_res} :
		(wb_adr_i == `MID_REG_DECODE)  ?
			{27'h000_0000, last_skip, last_two, vec, state} :
		(wb_adr_i == `MID_REG_CTRL)    ? {14'h0000, ctrl} : 32'h0000_0000;
	// registered ack, one cycle after the request; drops the next cycle
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd_mux;
		end
	end
	assign busy_o = (state != MID_IDLE);
endmodule // mid_decoder

// ### hw/mid_cfg.svh
// offsets, field positions, reset values and timing counts of the decoder
`ifndef MID_CFG_SVH
`define MID_CFG_SVH
// register byte offsets
`define MID_REG_INSN     8'h00
`define MID_REG_OPERAND  8'h04
`define MID_REG_ACC      8'h08
`define MID_REG_STATUS   8'h0C
`define MID_REG_RESULT   8'h10
`define MID_REG_DECODE   8'h14
`define MID_REG_CTRL     8'h18
// status bit positions
`define MID_ST_C         0
`define MID_ST_DC        1
`define MID_ST_Z         2
`define MID_ST_PD        3
`define MID_ST_TO        4
// control field positions
`define MID_CT_PSA       16
`define MID_CT_GIE       17
// reset values
`define MID_STATUS_RST   5'h18
`define MID_CTRL_RST     18'h0_0106
// timing: oscillator periods in one instruction cycle; interrupt vector
`define MID_OSC_PER_CYC  4
`define MID_IRQ_VECTOR   11'h004
// fixed control words
`define MID_W_CLRWD      14'h0064
`define MID_W_STBY       14'h0063
`define MID_W_IRET       14'h0009
`define MID_W_RET        14'h0008
`endif

// ### hw/mid_pkg.sv
// types shared by the instruction decoder
package mid_pkg;
	typedef enum logic [1:0] {
		MID_IDLE  = 2'b00,
		MID_EXEC  = 2'b01,
		MID_DUMMY = 2'b10
	} mid_state_e;
endpackage

// ### sim/mid_decoder_checker.sv
// concurrent checks on the decoder's ports
`timescale 1ns/1ps
module mid_decoder_checker (
	input wire logic       sys_clk_i,
	input wire logic       reset_n_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic       wb_ack_o,
	input wire logic       file_we_o,
	input wire logic       pc_load_o,
	input wire logic       stack_push_o,
	input wire logic       stack_pop_o,
	input wire logic       skip_o,
	input wire logic       wdt_clear_o,
	input wire logic       standby_o,
	input wire logic       prescaler_clear_o,
	input wire logic       busy_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// request decode; an insn write only starts work when idle
	wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire go  = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h00) & !busy_o;
	wire two = pc_load_o | stack_pop_o | skip_o;
	sequence s_first;
		busy_o [*4];
	endsequence
	sequence s_dummy;
		busy_o [*4] ##1 !busy_o;
	endsequence
	a_ack_answer: assert property (req |=> wb_ack_o)
		else $error("ack did not follow request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_insn_start: assert property (go |=> busy_o)
		else $error("instruction write did not start");
	a_cycle_min: assert property ($rose(busy_o) |-> s_first)
		else $error("instruction cycle shorter than four clocks");
	a_cycle_max: assert property ($rose(busy_o) ##3 1'b1 ##1 busy_o
		|-> s_dummy) else $error("bad two cycle length");
	a_two_cycle: assert property (two |-> s_dummy)
		else $error("branch or skip without dummy cycle");
	a_push_loads: assert property (stack_push_o |-> pc_load_o)
		else $error("push without pc load");
	a_standby_wdt: assert property (standby_o |-> wdt_clear_o)
		else $error("standby without watchdog clear");
	a_psc_write: assert property (prescaler_clear_o |-> file_we_o)
		else $error("prescaler clear without a write");
	a_we_pulse: assert property (file_we_o |=> !file_we_o [*3])
		else $error("file write repeated");
endmodule // mid_decoder_checker

bind mid_decoder mid_decoder_checker u_chk (.sys_clk_i, .reset_n_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_ack_o,
	.file_we_o, .pc_load_o, .stack_push_o, .stack_pop_o, .skip_o,
	.wdt_clear_o, .standby_o, .prescaler_clear_o, .busy_o);

// ### sim/tb.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic        we = 1'b0, irq = 1'b0;
	logic [7:0]  adr = 8'h00, pins = 8'h00, seen = 8'h00;
	logic [31:0] wdat = 32'h0000_0000, q, dat_o;
	logic        ack, fwe, pcl, push, pop, skp, wdc, sby, psc, busy;
	logic [6:0]  faddr;
	logic [7:0]  fdata;
	logic [10:0] pct;
	int          failures = 0, checked = 0, nbusy = 0, ticks = 0;
	// pulse masks: write, load, push, pop, skip, wdt, standby, prescaler
	localparam logic [7:0] m_we = 8'h80, m_pc = 8'h40, m_pu = 8'h20;
	localparam logic [7:0] m_po = 8'h10, m_sk = 8'h08, m_wd = 8'h04;
	localparam logic [7:0] m_sb = 8'h02, m_ps = 8'h01;

	mid_decoder dut (.sys_clk_i(clk), .reset_n_i(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.port_pins_i(pins), .irq_i(irq), .file_we_o(fwe),
		.file_addr_o(faddr), .file_data_o(fdata), .pc_load_o(pcl),
		.pc_target_o(pct), .stack_push_o(push), .stack_pop_o(pop),
		.skip_o(skp), .wdt_clear_o(wdc), .standby_o(sby),
		.prescaler_clear_o(psc), .busy_o(busy));

	always #4 clk = ~clk;

	// gather busy length and pulses; a hung run is cut short here
	always @(posedge clk) begin
		ticks++;
		if (busy) nbusy++;
		seen = seen | {fwe, pcl, push, pop, skp, wdc, sby, psc};
		if (ticks == 6000) begin
			failures++;
			final_report();
		end
	end

	task final_report;
		if (failures == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// one classic cycle; request held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask

	task setr(input logic [31:0] acc, opr, st);
		wb(1'b1, 8'h08, acc);
		wb(1'b1, 8'h04, opr);
		wb(1'b1, 8'h0C, st);
	endtask

	// run one word, then judge its length and its pulses
	task exec(input logic [13:0] w, input int n, input logic [7:0] m);
		nbusy = 0;
		seen = 8'h00;
		wb(1'b1, 8'h00, {18'h0_0000, w});
		while (busy !== 1'b0) @(posedge clk);
		@(posedge clk);
		chk(nbusy, n);
		chk(seen, m);
	endtask

	task t_reset;
		rd(8'h0C, 8'h18);
		rd(8'h18, 32'h0000_0106);
		rd(8'h1C, 8'h00);
	endtask

	task t_logic;
		setr(8'h0F, 8'hF0, 8'h1F);
		exec(14'h0485, 4, m_we);
		chk(faddr, 7'h05);
		chk(fdata, 8'hFF);
		rd(8'h0C, 8'h1B);
		rd(8'h10, 8'hFF);
		setr(8'h5A, 8'h5A, 8'h1B);
		exec(14'h067F, 4, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h0C, 8'h1F);
	endtask

	task t_rotate;
		setr(8'h00, 8'h80, 8'h19);
		exec(14'h0D90, 4, m_we);
		chk(fdata, 8'h01);
		rd(8'h0C, 8'h19);
		setr(8'h55, 8'h01, 8'h18);
		exec(14'h0C10, 4, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h0C, 8'h19);
	endtask

	task t_skip;
		setr(8'h00, 8'h01, 8'h18);
		exec(14'h0BA0, 8, m_we | m_sk);
		chk(fdata, 8'h00);
		rd(8'h0C, 8'h18);
		rd(8'h14, 8'h18);
		wb(1'b1, 8'h04, 8'h00);
		exec(14'h0F20, 4, 8'h00);
		rd(8'h08, 8'h01);
	endtask

	task t_bits;
		wb(1'b1, 8'h04, 8'hF7);
		exec(14'h19A0, 8, m_sk);
		wb(1'b1, 8'h04, 8'h7F);
		exec(14'h1FA0, 4, 8'h00);
		wb(1'b1, 8'h04, 8'h00);
		exec(14'h1420, 4, m_we);
		chk(fdata, 8'h01);
		wb(1'b1, 8'h04, 8'hFF);
		exec(14'h13A0, 4, m_we);
		chk(fdata, 8'h7F);
	endtask

	task t_literal;
		setr(8'h01, 8'h00, 8'h1F);
		exec(14'h3D00, 4, 8'h00);
		rd(8'h08, 8'hFF);
		rd(8'h0C, 8'h18);
		setr(8'h01, 8'h00, 8'h18);
		exec(14'h3C10, 4, 8'h00);
		rd(8'h08, 8'h0F);
		rd(8'h0C, 8'h19);
		setr(8'h00, 8'h00, 8'h1B);
		exec(14'h3800, 4, 8'h00);
		rd(8'h0C, 8'h1F);
		setr(8'h0F, 8'h00, 8'h1C);
		exec(14'h3AFF, 4, 8'h00);
		rd(8'h08, 8'hF0);
		rd(8'h0C, 8'h18);
	endtask

	task t_branch;
		exec(14'h2123, 8, m_pc | m_pu);
		chk(pct, 11'h123);
		exec(14'h2FFF, 8, m_pc);
		chk(pct, 11'h7FF);
		exec(14'h0008, 8, m_po);
		exec(14'h0009, 8, m_po);
		rd(8'h18, 32'h0002_0106);
		exec(14'h37A5, 8, m_po);
		rd(8'h08, 8'hA5);
	endtask

	task t_power;
		wb(1'b1, 8'h0C, 8'h00);
		exec(14'h0064, 4, m_wd);
		rd(8'h0C, 8'h18);
		wb(1'b1, 8'h0C, 8'h00);
		exec(14'h0063, 4, m_wd | m_sb);
		rd(8'h0C, 8'h10);
	endtask

	// timer count write and a port operand read from the pins
	task t_side;
		wb(1'b1, 8'h18, 32'h0001_0106);
		setr(8'h00, 8'h33, 8'h18);
		exec(14'h0881, 4, m_we | m_ps);
		chk(fdata, 8'h33);
		rd(8'h10, 8'h33);
		wb(1'b1, 8'h18, 32'h0000_0106);
		exec(14'h0881, 4, m_we);
		pins <= 8'hA5;
		exec(14'h0886, 4, m_we);
		chk(fdata, 8'hA5);
	endtask

	task t_irq;
		wb(1'b1, 8'h18, 32'h0002_0106);
		nbusy = 0;
		seen = 8'h00;
		irq <= 1'b1;
		@(posedge clk);
		while (busy !== 1'b1) @(posedge clk);
		irq <= 1'b0;
		while (busy !== 1'b0) @(posedge clk);
		@(posedge clk);
		chk(seen, m_pc | m_pu);
		chk(pct, 11'h004);
		chk(nbusy, 8);
		rd(8'h18, 32'h0000_0106);
		rd(8'h14, 8'h0C);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_logic();
		t_rotate();
		t_skip();
		t_bits();
		t_literal();
		t_branch();
		t_power();
		t_side();
		t_irq();
		final_report();
	end
endmodule // tb
